// >>> hw/mm_decoder_defines.svh
// Address map, register offsets, field positions and reset values of the data-space decoder
// Included by bare name from the decoder modules; definitions only
`ifndef MM_DECODER_DEFINES_SVH
`define MM_DECODER_DEFINES_SVH
////////////////////////////////////////////////////////////////////////////////
// Data-space boundaries
`define FAST_LO       16'hfe00
`define FAST_HI       16'hfeff
`define SHORT_LO      16'hfe20
`define GPR_LO        16'hfee0
`define MACRO_LO      16'hfec2
`define MACRO_LO_RF   16'hfed4
`define MACRO_HI      16'hfedf
`define NVM_LO        16'hfb00
`define NVM_HI        16'hfcff
`define SFR_LO        16'hff00
`define XSFR_LO       16'hffd0
`define XSFR_HI       16'hffdf
`define RAM_LO_0      16'hfd80
`define RAM_LO_1      16'hfd00
`define RAM_LO_2      16'hfc80
`define RAM_LO_3      16'hfb00
`define ROM_HI_8K     16'h1fff
`define ROM_HI_16K    16'h3fff
`define ROM_HI_32K    16'h7fff
////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define REG_MODE      8'h00
`define REG_LATCH     8'h04
`define REG_DIR       8'h08
`define REG_CFG       8'h0c
`define REG_STAT      8'h10
////////////////////////////////////////////////////////////////////////////////
// Field positions
`define MODE_EXT_EN   0
`define MODE_MEG      1
`define CFG_REF_VAR   0
`define CFG_REF_ON    1
`define CFG_NVM       2
`define CFG_ROMLESS   3
`define CFG_ROM_LSB   4
`define CFG_RAM_LSB   6
`define STAT_LOCK     0
`define STAT_FETCH    1
`define STAT_SHORT    2
`define STAT_SCRATCH  3
`define STAT_EXT      4
`define STAT_NVM      5
////////////////////////////////////////////////////////////////////////////////
// Reset values
`define MODE_RST      8'h00
`define LATCH_RST     8'h00
`define DIR_RST       8'h00
`define CFG_RST       8'h10
`endif

// >>> hw/mm_decoder_pkg.sv
// Types shared by the data-space decoder modules
// Assumes nothing beyond a SystemVerilog compiler
package mm_decoder_pkg;

  typedef enum logic [2:0] {
    RGN_ROM,
    RGN_EXTMEM,
    RGN_NVM,
    RGN_SCRATCH,
    RGN_FAST,
    RGN_SFR,
    RGN_EXTSFR
  } region_t;

  typedef enum logic {
    ST_RUN,
    ST_LOCKED
  } state_t;

endpackage

// >>> hw/mm_region_classify.sv
// Combinational classifier of a 16-bit data address into its region
// Assumes the caller registers the result and handles faults
`include "mm_decoder_defines.svh"

module mm_region_classify
(
  // Address under test
  input  wire logic [15:0]           addr,
  // Configuration
  input  wire logic                  refreshVar,
  input  wire logic                  nvmFitted,
  input  wire logic                  romLess,
  input  wire logic                  busOpen,
  input  wire logic [1:0]            romSize,
  input  wire logic [1:0]            ramSize,
  // Result
  output mm_decoder_pkg::region_t    region,
  output logic                       fastShort,
  output logic                       gprHit,
  output logic                       macroHit
);

  function automatic logic inRange(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction

  logic [15:0] ramLo;
  logic [15:0] romHi;

  always_comb
  begin
    case (ramSize)
      2'h0:    ramLo = `RAM_LO_0;
      2'h1:    ramLo = `RAM_LO_1;
      2'h2:    ramLo = `RAM_LO_2;
      default: ramLo = `RAM_LO_3;
    endcase
    case (romSize)
      2'h0:    romHi = `ROM_HI_8K;
      2'h1:    romHi = `ROM_HI_16K;
      default: romHi = `ROM_HI_32K;
    endcase
  end

  always_comb
  begin
    if (addr >= `SFR_LO)
      region = (inRange(addr, `XSFR_LO, `XSFR_HI) && !refreshVar && busOpen) ?
               mm_decoder_pkg::RGN_EXTSFR : mm_decoder_pkg::RGN_SFR;
    else if (inRange(addr, `FAST_LO, `FAST_HI))
      region = mm_decoder_pkg::RGN_FAST;
    else if (nvmFitted && inRange(addr, `NVM_LO, `NVM_HI))
      region = mm_decoder_pkg::RGN_NVM;
    else if (addr >= ramLo)
      region = mm_decoder_pkg::RGN_SCRATCH;
    else if (!romLess && addr <= romHi)
      region = mm_decoder_pkg::RGN_ROM;
    else
      region = mm_decoder_pkg::RGN_EXTMEM;
    fastShort = inRange(addr, `SHORT_LO, `FAST_HI);
    gprHit    = inRange(addr, `GPR_LO, `FAST_HI);
    macroHit  = inRange(addr, refreshVar ? `MACRO_LO_RF : `MACRO_LO, `MACRO_HI);
  end

endmodule

// >>> hw/mm_csr_slave.sv
// Avalon-MM register file of the decoder: mode, bank and configuration registers
// Assumes a master that holds its request until waitrequest is seen low
`include "mm_decoder_defines.svh"

module mm_csr_slave
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Register contents
  input  wire logic [7:0]  status,
  output logic      [7:0]  modeReg,
  output logic      [7:0]  latchReg,
  output logic      [7:0]  dirReg,
  output logic      [7:0]  cfgReg,
  output logic      [7:0]  statClear
);

  logic wrLow;

  assign wrLow = write && !waitrequest && byteenable[0];

  // One wait state per access
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      waitrequest <= 1'b1;
    else
      waitrequest <= !((read || write) && waitrequest);
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      readdata <= 32'h0;
    else if (read && waitrequest)
      case (address)
        `REG_MODE:  readdata <= {24'h0, modeReg};
        `REG_LATCH: readdata <= {24'h0, latchReg};
        `REG_DIR:   readdata <= {24'h0, dirReg};
        `REG_CFG:   readdata <= {24'h0, cfgReg};
        `REG_STAT:  readdata <= {24'h0, status};
        default:    readdata <= 32'h0;
      endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      modeReg  <= `MODE_RST;
      latchReg <= `LATCH_RST;
      dirReg   <= `DIR_RST;
      cfgReg   <= `CFG_RST;
    end
    else if (wrLow)
      case (address)
        `REG_MODE:  modeReg  <= writedata[7:0];
        `REG_LATCH: latchReg <= writedata[7:0];
        `REG_DIR:   dirReg   <= writedata[7:0];
        `REG_CFG:   cfgReg   <= writedata[7:0];
        default:    ;
      endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      statClear <= 8'h00;
    else
      statClear <= (wrLow && address == `REG_STAT) ? writedata[7:0] : 8'h00;
  end

endmodule

// >>> hw/memory_map_bank_decoder.sv
// Data-space decoder with one-megabyte bank extension and access checks
// Assumes CPU request signals and the peripheral hit flag are synchronous to clock
//
// Contract
// - Top 256 bytes of internal RAM decode as fast RAM, apart from scratch RAM.
// - Short direct addressing reaches only fast RAM from 0FE20H to 0FEFFH.
// - Four banks of eight working registers sit at the top 32 fast RAM bytes.
// - Transfer control words occupy 0FEC2H to 0FEDFH, from 0FED4H in refresh variant.
// - Instruction fetch from internal RAM is refused; RAM serves data only.
// - Refresh variant: scratch RAM unusable while refresh is enabled.
// - With nonvolatile memory fitted, 0FB00H to 0FCFFH decode as persistent storage.
// - 0FF00H to 0FFFFH decode as the peripheral register area.
// - Unassigned peripheral address access deadlocks; only reset clears it.
// - Outside refresh variant, 0FFD0H to 0FFDFH go external when ROM-less or expanded.
// - External register window uses the same bus cycles as external memory.
// - Unclaimed addresses go external only when expansion mode or the ROM-less configuration enables it, or when an extended access selects a nonzero bank.
// - One-megabyte mode turns four port-six pins into address bits 16 to 19.
// - Extended space is sixteen 64K banks selected by a 4-bit bank value.
// - Bank value drives the high lines only during extended instructions.
// - Ampersand operand takes bank from port-six latch, else from direction-register nibble.
`include "mm_decoder_defines.svh"

module memory_map_bank_decoder
(
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  // Avalon-MM register port
  input  wire logic [7:0]            address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [3:0]            byteenable,
  input  wire logic [31:0]           writedata,
  output logic      [31:0]           readdata,
  output logic                       waitrequest,
  // CPU access request
  input  wire logic                  cpuReq,
  input  wire logic [15:0]           cpuAddr,
  input  wire logic                  cpuFetch,
  input  wire logic                  cpuShortDirect,
  input  wire logic                  cpuExtended,
  input  wire logic                  cpuAmpPrefix,
  input  wire logic                  cpuWordStore,
  input  wire logic                  cpuRotate,
  // Peripheral register presence
  input  wire logic                  sfrAssigned,
  // Decode answer
  output logic                       respValid,
  output mm_decoder_pkg::region_t    respRegion,
  output logic      [19:0]           respAddr,
  output logic                       respFault,
  output logic                       respExtBus,
  output logic                       respShort,
  output logic                       respGpr,
  output logic                       respMacro,
  // High address pins
  output logic      [3:0]            highAddr,
  output logic                       highAddrOe_n,
  // Lock state
  output logic                       deadlocked
);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and configuration
  logic [7:0]                modeReg;
  logic [7:0]                latchReg;
  logic [7:0]                dirReg;
  logic [7:0]                cfgReg;
  logic [7:0]                statClear;
  logic [7:0]                status;
  logic [5:1]                sticky_q;
  logic [5:1]                stickySet;
  mm_decoder_pkg::state_t    state_q;
  mm_decoder_pkg::state_t    state_d;
  mm_decoder_pkg::region_t   rgn;
  mm_decoder_pkg::region_t   effRgn;
  logic                      fastShort;
  logic                      gprHit;
  logic                      macroHit;
  logic                      extEn;
  logic                      meg1;
  logic                      refreshVar;
  logic                      refreshOn;
  logic                      nvmFitted;
  logic                      romLess;
  logic                      busOpen;
  logic [3:0]                bank;
  logic                      useBank;
  logic                      highBank;
  logic                      fetchErr;
  logic                      shortErr;
  logic                      scratchErr;
  logic                      extErr;
  logic                      nvmErr;
  logic                      sfrErr;
  logic                      anyErr;
  logic                      take;

  mm_csr_slave u_mm_csr_slave
  (
    .clock       (clock),
    .rst_n       (rst_n),
    .address     (address),
    .read        (read),
    .write       (write),
    .byteenable  (byteenable),
    .writedata   (writedata),
    .readdata    (readdata),
    .waitrequest (waitrequest),
    .status      (status),
    .modeReg     (modeReg),
    .latchReg    (latchReg),
    .dirReg      (dirReg),
    .cfgReg      (cfgReg),
    .statClear   (statClear)
  );

  assign extEn      = modeReg[`MODE_EXT_EN];
  assign meg1       = modeReg[`MODE_MEG];
  assign refreshVar = cfgReg[`CFG_REF_VAR];
  assign refreshOn  = cfgReg[`CFG_REF_ON];
  assign nvmFitted  = cfgReg[`CFG_NVM];
  assign romLess    = cfgReg[`CFG_ROMLESS];
  assign busOpen    = extEn || romLess;

  ////////////////////////////////////////////////////////////////////////////////
  // Region decode
  mm_region_classify u_mm_region_classify
  (
    .addr       (cpuAddr),
    .refreshVar (refreshVar),
    .nvmFitted  (nvmFitted),
    .romLess    (romLess),
    .busOpen    (busOpen),
    .romSize    (cfgReg[`CFG_ROM_LSB +: 2]),
    .ramSize    (cfgReg[`CFG_RAM_LSB +: 2]),
    .region     (rgn),
    .fastShort  (fastShort),
    .gprHit     (gprHit),
    .macroHit   (macroHit)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Bank selection and access checks
  assign bank     = cpuAmpPrefix ? latchReg[3:0] : dirReg[3:0];
  assign useBank  = cpuExtended && meg1;
  assign highBank = useBank && (bank != 4'h0);
  assign effRgn   = highBank ? mm_decoder_pkg::RGN_EXTMEM : rgn;
  assign take     = cpuReq && (state_q == mm_decoder_pkg::ST_RUN);

  assign fetchErr   = cpuFetch && (effRgn == mm_decoder_pkg::RGN_FAST || effRgn == mm_decoder_pkg::RGN_SCRATCH);
  assign shortErr   = cpuShortDirect && !fastShort;
  assign scratchErr = (effRgn == mm_decoder_pkg::RGN_SCRATCH) && refreshVar && refreshOn;
  assign extErr     = (effRgn == mm_decoder_pkg::RGN_EXTMEM) && !busOpen && !highBank;
  // Word stores and digit rotates onto persistent storage are flagged
  assign nvmErr     = (effRgn == mm_decoder_pkg::RGN_NVM) && (cpuWordStore || cpuRotate);
  assign sfrErr     = (effRgn == mm_decoder_pkg::RGN_SFR) && !sfrAssigned && !shortErr;
  assign anyErr     = fetchErr || shortErr || scratchErr || extErr || nvmErr;

  ////////////////////////////////////////////////////////////////////////////////
  // Lock state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      mm_decoder_pkg::ST_RUN:
        if (take && sfrErr)
          state_d = mm_decoder_pkg::ST_LOCKED;
      mm_decoder_pkg::ST_LOCKED:
        state_d = mm_decoder_pkg::ST_LOCKED;
      default:
        state_d = mm_decoder_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      state_q <= mm_decoder_pkg::ST_RUN;
    else
      state_q <= state_d;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      deadlocked <= 1'b0;
    else
      deadlocked <= (state_d == mm_decoder_pkg::ST_LOCKED);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decode answer, one cycle after the request
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      respValid <= 1'b0;
    else
      respValid <= take && !sfrErr;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      respRegion <= mm_decoder_pkg::RGN_ROM;
      respAddr   <= 20'h00000;
      respFault  <= 1'b0;
      respExtBus <= 1'b0;
      respShort  <= 1'b0;
      respGpr    <= 1'b0;
      respMacro  <= 1'b0;
    end
    else if (take)
    begin
      respRegion <= effRgn;
      respAddr   <= {useBank ? bank : 4'h0, cpuAddr};
      respFault  <= anyErr;
      // Window and memory share one external cycle type
      respExtBus <= !anyErr && (effRgn == mm_decoder_pkg::RGN_EXTMEM || effRgn == mm_decoder_pkg::RGN_EXTSFR);
      respShort  <= cpuShortDirect && fastShort && !highBank;
      respGpr    <= gprHit && !highBank;
      respMacro  <= macroHit && !highBank;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      highAddr     <= 4'h0;
      highAddrOe_n <= 1'b1;
    end
    else
    begin
      highAddr     <= (take && useBank) ? bank : 4'h0;
      highAddrOe_n <= !(take && useBank);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky fault causes, set wins over clear
  assign stickySet = take ? {nvmErr, extErr, scratchErr, shortErr, fetchErr} : 5'h00;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      sticky_q <= 5'h00;
    else
      sticky_q <= (sticky_q & ~statClear[5:1]) | stickySet;
  end

  assign status = {2'h0, sticky_q, deadlocked};

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_fetchRam;
    @(posedge clock) disable iff (!rst_n)
    take && cpuFetch && !useBank && cpuAddr[15:8] == 8'hfe |=> respValid && respFault;
  endproperty
  a_fetchRam: assert property (p_fetchRam) else $error("Fetch from fast RAM not refused");

  property p_shortLow;
    @(posedge clock) disable iff (!rst_n)
    take && cpuShortDirect && cpuAddr >= `FAST_LO && cpuAddr < `SHORT_LO |=> respFault && !respShort;
  endproperty
  a_shortLow: assert property (p_shortLow) else $error("Short direct below window accepted");

  property p_fastData;
    @(posedge clock) disable iff (!rst_n)
    take && !useBank && !cpuFetch && cpuAddr >= `SHORT_LO && cpuAddr <= `FAST_HI
      |=> respRegion == mm_decoder_pkg::RGN_FAST && !respFault;
  endproperty
  a_fastData: assert property (p_fastData) else $error("Fast RAM data access misdecoded");

  property p_gpr;
    @(posedge clock) disable iff (!rst_n)
    take && !useBank && cpuAddr >= `GPR_LO && cpuAddr <= `FAST_HI |=> respGpr;
  endproperty
  a_gpr: assert property (p_gpr) else $error("Working register bytes not flagged");

  property p_macro;
    @(posedge clock) disable iff (!rst_n)
    take && !useBank && cpuAddr >= `MACRO_LO && cpuAddr < `MACRO_LO_RF |=> respMacro == !$past(refreshVar);
  endproperty
  a_macro: assert property (p_macro) else $error("Control word range start wrong");

  property p_scratch;
    @(posedge clock) disable iff (!rst_n)
    take && !useBank && !cpuFetch && !cpuShortDirect && rgn == mm_decoder_pkg::RGN_SCRATCH
      && !(refreshVar && refreshOn) |=> respRegion == mm_decoder_pkg::RGN_SCRATCH && !respFault;
  endproperty
  a_scratch: assert property (p_scratch) else $error("Scratch RAM data access misdecoded");

  property p_scratchOff;
    @(posedge clock) disable iff (!rst_n)
    take && rgn == mm_decoder_pkg::RGN_SCRATCH && !highBank && refreshVar && refreshOn |=> respFault;
  endproperty
  a_scratchOff: assert property (p_scratchOff) else $error("Scratch RAM usable during refresh");

  property p_nvm;
    @(posedge clock) disable iff (!rst_n)
    take && !useBank && nvmFitted && cpuAddr >= `NVM_LO && cpuAddr <= `NVM_HI
      |=> respRegion == mm_decoder_pkg::RGN_NVM;
  endproperty
  a_nvm: assert property (p_nvm) else $error("Persistent storage misdecoded");

  property p_sfr;
    @(posedge clock) disable iff (!rst_n)
    take && !useBank && cpuAddr >= `SFR_LO && cpuAddr < `XSFR_LO && sfrAssigned && !cpuShortDirect
      |=> respValid && respRegion == mm_decoder_pkg::RGN_SFR;
  endproperty
  a_sfr: assert property (p_sfr) else $error("Peripheral area misdecoded");

  property p_lock;
    @(posedge clock) disable iff (!rst_n)
    take && sfrErr |=> (deadlocked && !respValid) [*4];
  endproperty
  a_lock: assert property (p_lock) else $error("Unassigned peripheral access did not lock");

  property p_xsfr;
    @(posedge clock) disable iff (!rst_n)
    take && !useBank && !cpuFetch && !cpuShortDirect && cpuAddr >= `XSFR_LO && cpuAddr <= `XSFR_HI
      && !refreshVar && busOpen |=> respExtBus && respRegion == mm_decoder_pkg::RGN_EXTSFR;
  endproperty
  a_xsfr: assert property (p_xsfr) else $error("External register window not routed out");

  property p_extOff;
    @(posedge clock) disable iff (!rst_n)
    take && rgn == mm_decoder_pkg::RGN_EXTMEM && !busOpen && !highBank |=> respFault && !respExtBus;
  endproperty
  a_extOff: assert property (p_extOff) else $error("External access while expansion off");

  property p_pinsIdle;
    @(posedge clock) disable iff (!rst_n)
    !(take && useBank) |=> highAddrOe_n;
  endproperty
  a_pinsIdle: assert property (p_pinsIdle) else $error("High address lines driven outside extended access");

  property p_bankLatch;
    @(posedge clock) disable iff (!rst_n)
    take && useBank && cpuAmpPrefix |=> !highAddrOe_n && highAddr == $past(latchReg[3:0]);
  endproperty
  a_bankLatch: assert property (p_bankLatch) else $error("Prefixed access used wrong bank");

  property p_addr;
    @(posedge clock) disable iff (!rst_n)
    take && useBank && !cpuAmpPrefix |=> respAddr == {$past(dirReg[3:0]), $past(cpuAddr)};
  endproperty
  a_addr: assert property (p_addr) else $error("Extended address not bank above operand");

  property p_bankExt;
    @(posedge clock) disable iff (!rst_n)
    take && highBank && !cpuShortDirect |=> respExtBus && respRegion == mm_decoder_pkg::RGN_EXTMEM;
  endproperty
  a_bankExt: assert property (p_bankExt) else $error("Nonzero bank not routed external");

endmodule

// >>> bench/cpu_access_model.sv
// CPU-side request model for the data-space decoder
// Assumes the bench calls issue after reset release
module cpu_access_model
(
  // Clock
  input  wire logic        clock,
  // Request to decoder
  output logic             cpuReq,
  output logic      [15:0] cpuAddr,
  output logic             cpuFetch,
  output logic             cpuShortDirect,
  output logic             cpuExtended,
  output logic             cpuAmpPrefix,
  output logic             cpuWordStore,
  output logic             cpuRotate,
  output logic             sfrAssigned
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    cpuReq = 1'b0;
    cpuAddr = 16'h0000;
    {cpuFetch, cpuShortDirect, cpuExtended, cpuAmpPrefix, sfrAssigned} = 5'h00;
    cpuWordStore = 1'b0;
    cpuRotate = 1'b0;
  end
  // One-cycle request, then answer cycle; address scrambled once released
  task automatic issue(input logic [15:0] a, input logic [4:0] f);
    @(posedge clock);
    cpuReq <= 1'b1;
    cpuAddr <= a;
    {cpuFetch, cpuShortDirect, cpuExtended, cpuAmpPrefix, sfrAssigned} <= f;
    @(posedge clock);
    cpuReq <= 1'b0;
    cpuAddr <= ~a;
    #1;
  endtask
endmodule

// >>> bench/memory_map_bank_decoder_tb.sv
// Self-checking bench of the data-space decoder
// Assumes the CPU model drives requests and the bench drives the register bus
module memory_map_bank_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [4:0] F_FETCH = 5'h10, F_SHORT = 5'h08, F_EXT = 5'h04, F_AMP = 5'h02, F_SFR = 5'h01;
  logic clock, rst_n, read, write, waitrequest, respValid, respFault, respExtBus, respShort;
  logic respGpr, respMacro, highAddrOe_n, deadlocked, cpuReq, cpuFetch, cpuShortDirect;
  logic cpuExtended, cpuAmpPrefix, cpuWordStore, cpuRotate, sfrAssigned;
  logic [7:0] address;
  logic [3:0] byteenable, highAddr;
  logic [31:0] writedata, readdata, d;
  logic [15:0] cpuAddr;
  logic [19:0] respAddr;
  mm_decoder_pkg::region_t respRegion;
  int n_errors = 0, total_checks = 0, cycles = 0;
  memory_map_bank_decoder u_memory_map_bank_decoder (.*);
  cpu_access_model u_cpu_access_model (.*);
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors = n_errors + 1;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    address <= a;
    writedata <= {24'h000000, v};
    write <= wr;
    read <= ~wr;
    do @(posedge clock); while (waitrequest !== 1'b0);
    d = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic resp(input logic [15:0] a, input logic [4:0] f, input mm_decoder_pkg::region_t rg, input logic flt);
    u_cpu_access_model.issue(a, f);
    check(32'(respValid), 32'h1, "valid");
    check(32'(respFault), 32'(flt), "fault");
    if (!flt)
      check(32'(respRegion), 32'(rg), "region");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    bus(1'b0, 8'h0c, 8'h00);
    check(d, 32'h10, "cfg reset");
    bus(1'b0, 8'h20, 8'h00);
    check(d, 32'h0, "unmapped");
    byteenable <= 4'he;
    bus(1'b1, 8'h08, 8'h0f);
    byteenable <= 4'hf;
    bus(1'b0, 8'h08, 8'h00);
    check(d, 32'h0, "byteenable");
  endtask
  task automatic t_fast();
    resp(16'hfe30, F_SHORT, mm_decoder_pkg::RGN_FAST, 1'b0);
    check(32'(respShort), 32'h1, "short");
    resp(16'hfe10, F_SHORT, mm_decoder_pkg::RGN_FAST, 1'b1);
    resp(16'hfe00, 5'h00, mm_decoder_pkg::RGN_FAST, 1'b0);
    resp(16'hfdff, 5'h00, mm_decoder_pkg::RGN_SCRATCH, 1'b0);
    resp(16'hfee5, 5'h00, mm_decoder_pkg::RGN_FAST, 1'b0);
    check(32'(respGpr), 32'h1, "gpr");
    resp(16'hfec1, 5'h00, mm_decoder_pkg::RGN_FAST, 1'b0);
    check(32'(respMacro), 32'h0, "macro");
    resp(16'hfe30, F_FETCH, mm_decoder_pkg::RGN_FAST, 1'b1);
    bus(1'b0, 8'h10, 8'h00);
    check(d, 32'h06, "sticky");
    bus(1'b1, 8'h10, 8'h06);
    bus(1'b0, 8'h10, 8'h00);
    check(d, 32'h0, "cleared");
  endtask
  task automatic t_refresh();
    bus(1'b1, 8'h00, 8'h01);
    bus(1'b1, 8'h0c, 8'h13);
    resp(16'hfd90, 5'h00, mm_decoder_pkg::RGN_SCRATCH, 1'b1);
    resp(16'hfed4, 5'h00, mm_decoder_pkg::RGN_FAST, 1'b0);
    check(32'(respMacro), 32'h1, "macro");
    resp(16'hffd5, F_SFR, mm_decoder_pkg::RGN_SFR, 1'b0);
  endtask
  task automatic t_nvm_ext();
    bus(1'b1, 8'h0c, 8'h14);
    resp(16'hfb00, 5'h00, mm_decoder_pkg::RGN_NVM, 1'b0);
    resp(16'hff10, F_SFR, mm_decoder_pkg::RGN_SFR, 1'b0);
    resp(16'hffd5, F_SFR, mm_decoder_pkg::RGN_EXTSFR, 1'b0);
    check(32'(respExtBus), 32'h1, "extbus");
    resp(16'h9000, 5'h00, mm_decoder_pkg::RGN_EXTMEM, 1'b0);
    check(32'(respExtBus), 32'h1, "extbus");
    bus(1'b1, 8'h00, 8'h00);
    resp(16'h9000, 5'h00, mm_decoder_pkg::RGN_EXTMEM, 1'b1);
    resp(16'h1000, 5'h00, mm_decoder_pkg::RGN_ROM, 1'b0);
    bus(1'b1, 8'h0c, 8'hc8);
    resp(16'h1000, 5'h00, mm_decoder_pkg::RGN_EXTMEM, 1'b0);
    resp(16'hffd5, F_SFR, mm_decoder_pkg::RGN_EXTSFR, 1'b0);
    resp(16'hfb00, 5'h00, mm_decoder_pkg::RGN_SCRATCH, 1'b0);
    bus(1'b1, 8'h0c, 8'h24);
    resp(16'h7000, 5'h00, mm_decoder_pkg::RGN_ROM, 1'b0);
  endtask
  task automatic t_bank();
    bus(1'b1, 8'h00, 8'h03);
    bus(1'b1, 8'h04, 8'h05);
    bus(1'b1, 8'h08, 8'h03);
    bus(1'b0, 8'h04, 8'h00);
    check(d, 32'h05, "latch");
    resp(16'h1234, F_EXT | F_AMP, mm_decoder_pkg::RGN_EXTMEM, 1'b0);
    check({27'h0, highAddrOe_n, highAddr}, 32'h05, "pins");
    check(32'(respAddr), 32'h51234, "addr");
    @(posedge clock);
    #1;
    check(32'(highAddrOe_n), 32'h1, "oe");
    resp(16'h1234, F_EXT, mm_decoder_pkg::RGN_EXTMEM, 1'b0);
    check(32'(respAddr), 32'h31234, "addr");
    resp(16'h1234, 5'h00, mm_decoder_pkg::RGN_ROM, 1'b0);
    check({11'h0, highAddrOe_n, respAddr}, 32'h101234, "plain");
    bus(1'b1, 8'h08, 8'h00);
    resp(16'h1234, F_EXT, mm_decoder_pkg::RGN_ROM, 1'b0);
    check(32'(respAddr), 32'h01234, "bank0");
  endtask
  task automatic t_lock();
    u_cpu_access_model.issue(16'hff20, 5'h00);
    check(32'({respValid, deadlocked}), 32'h1, "lock");
    u_cpu_access_model.issue(16'hfe30, 5'h00);
    check(32'({respValid, deadlocked}), 32'h1, "held");
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    resp(16'hfe30, 5'h00, mm_decoder_pkg::RGN_FAST, 1'b0);
    check(32'(deadlocked), 32'h0, "unlock");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    {read, write, address, writedata} = 42'h0;
    byteenable = 4'hf;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_fast();
    t_refresh();
    t_nvm_ext();
    t_bank();
    t_lock();
    tally_and_finish();
  end
endmodule
